// *** include/rtac_pkg.sv ***
// Purpose: shared constants for the retimer channel adapt/lock control
// Assumes: one 250 MHz clock, 25 MHz reference seen as an enable pulse
// Notes:   offsets are channel register byte indices
package rtac_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] OFS_SWING       = 8'h2d;
   localparam logic [7:0] OFS_RATE        = 8'h2f;
   localparam logic [7:0] OFS_DEEMPH      = 8'h2e;
   localparam logic [7:0] OFS_CTRL        = 8'h30;
   localparam logic [7:0] OFS_STATUS      = 8'h31;
   localparam logic [7:0] OFS_COARSE      = 8'h32;
   localparam logic [7:0] OFS_MON         = 8'h3e;
   localparam logic [7:0] OFS_TABLE_LO    = 8'h40;
   localparam logic [7:0] OFS_TABLE_HI    = 8'h5f;
   localparam logic [7:0] OFS_RATE_X0     = 8'h60;
   localparam logic [7:0] OFS_RATE_X4     = 8'h64;
   // ****************************************
   // field positions
   // ****************************************
   localparam int SWING_MSB      = 2;
   localparam int RATE_LSB       = 4;
   localparam int MON_EN_BIT     = 7;
   localparam int CTRL_SD_OVR    = 0;  // force data path off
   localparam int CTRL_LIMIT4    = 1;  // stage four limiting
   localparam int CTRL_READAPT   = 2;  // self-clearing command
   localparam int CTRL_CDR_RST   = 3;  // self-clearing command
   localparam int CTRL_MANUAL    = 4;  // manual ppm target
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] MON_RST    = 8'h80;
   localparam logic [7:0] SWING_RST  = 8'h04;
   localparam logic [7:0] RATE_RST   = 8'h00;
   localparam logic [7:0] TABLE_RST  = 8'h55;
   // ****************************************
   // timing
   // ****************************************
   localparam int CLK_MHZ        = 250;
   localparam int REF_MHZ        = 25;
   localparam int REF_DIV        = CLK_MHZ / REF_MHZ;
   localparam int WIN_REF_CYC    = 64;   // count window in reference ticks
   localparam int SETTLE_CYC     = 16;   // per-entry merit settle
   localparam int MAX_RETRY      = 4;
   localparam int TABLE_N        = 32;
   localparam int COARSE_N       = 16;
endpackage

// *** verilog/rtac_cal.sv ***
`timescale 1ns/1ps
// Purpose: VCO coarse-tune calibration sweep for one channel
// Assumes: vco_tick pulses once per divided VCO period
// Notes:   keeps the code whose count lies closest to target
module rtac_cal #(
   parameter int CW = 4
) (
   // clock and reset
   input  wire logic            clk,
   input  wire logic            rst_n,
   // control
   input  wire logic            start,
   input  wire logic            ref_en,
   input  wire logic            vco_tick,
   input  wire logic [15:0]     target,
   // result
   output logic [CW-1:0]        code,
   output logic                 busy
);
   initial if (CW < 1 || CW > 8) $error("rtac_cal: CW out of range");
   logic [CW-1:0] try_r;
   logic [CW-1:0] keep_r;
   logic [15:0]   cnt_r;
   logic [15:0]   best_r;
   logic [7:0]    win_r;
   logic [15:0]   diff;
   // absolute distance of this count to target
   assign diff = (cnt_r > target) ? cnt_r - target : target - cnt_r;
   // sweep every code, one reference window each
   // code shows the trial code while sweeping so the vco runs at the code under test
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         try_r  <= '0;
         keep_r <= '0;
         cnt_r  <= '0;
         best_r <= 16'hffff;
         win_r  <= '0;
         code   <= '0;
         busy   <= 1'b0;
      end else if (start) begin
         busy   <= 1'b1;
         try_r  <= '0;
         code   <= '0;
         cnt_r  <= '0;
         win_r  <= '0;
         best_r <= 16'hffff;
      end else if (busy) begin
         if (vco_tick)
            cnt_r <= cnt_r + 16'h0001;
         if (ref_en) begin
            if (win_r == 8'(rtac_pkg::WIN_REF_CYC - 1)) begin
               win_r <= '0;
               cnt_r <= '0;
               if (diff < best_r) begin
                  best_r <= diff;
                  keep_r <= try_r;
               end
               if (try_r == {CW{1'b1}}) begin
                  busy <= 1'b0;
                  code <= (diff < best_r) ? try_r : keep_r;  // closest code is kept
               end else begin
                  try_r <= try_r + 1'b1;
                  code  <= try_r + 1'b1;
               end
            end else
               win_r <= win_r + 8'h01;
         end
      end
   end
endmodule

// *** verilog/rtac_adapt.sv ***
`timescale 1ns/1ps
// Purpose: boost table walk with merit scoring for one channel
// Assumes: merit input is valid after settle cycles per entry
// Notes:   result freezes until restart
module rtac_adapt (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // control
   input  wire logic        start,
   input  wire logic [7:0]  merit,
   // table port
   output logic [4:0]       idx,
   // result
   output logic [4:0]       best,
   output logic             busy
);
   logic [7:0] best_m_r;
   logic [4:0] wait_r;
   // score each of the 32 entries, keep the best
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx      <= '0;
         best     <= '0;
         best_m_r <= '0;
         wait_r   <= '0;
         busy     <= 1'b0;
      end else if (start) begin
         idx      <= '0;
         best_m_r <= '0;
         wait_r   <= '0;
         busy     <= 1'b1;
      end else if (busy) begin
         if (wait_r == 5'(rtac_pkg::SETTLE_CYC - 1)) begin
            wait_r <= '0;
            if (merit >= best_m_r) begin
               best_m_r <= merit;
               best     <= idx;
            end
            if (idx == 5'(rtac_pkg::TABLE_N - 1))
               busy <= 1'b0;
            else
               idx <= idx + 5'd1;
         end else
            wait_r <= wait_r + 5'd1;
      end
   end
endmodule

// *** verilog/rtac_channel.sv ***
`timescale 1ns/1ps
// Purpose: per-channel adapt, calibration and lock control of a retimer
// Assumes: register port strobes one cycle, read data the cycle after
// Notes:   one instance per channel; channels share nothing
module rtac_channel #(
   parameter int CW = 4
) (
   // clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // register port
   input  wire logic [7:0]    addr,
   input  wire logic [7:0]    wdata,
   input  wire logic          wr,
   input  wire logic          rd,
   output logic [7:0]         rdata,
   // analog front end status
   input  wire logic          sig_det,
   input  wire logic          vco_tick,
   input  wire logic          cdr_locked,
   input  wire logic          eye_ok,
   input  wire logic [7:0]    merit,
   // analog controls
   output logic               path_pwr,
   output logic [7:0]         stage_boost,
   output logic [5:0]         boost_level,
   output logic               stage4_limit,
   output logic [CW-1:0]      coarse_code,
   output logic [2:0]         output_swing_level,
   output logic [7:0]         deemph,
   output logic               data_out_en
);
   // ****************************************
   // registers
   // ****************************************
   typedef enum logic [2:0] {RTAC_OFF, RTAC_CAL, RTAC_ACQ, RTAC_ADAPT, RTAC_RUN} rtac_st_t;
   rtac_st_t   st_r;
   logic [7:0] swing_r, rate_r, deemph_r, ctrl_r, mon_r;
   logic [7:0] rate_x_r [5];
   logic [7:0] table_r [rtac_pkg::TABLE_N];
   logic [2:0] retry_r;
   logic [3:0] ref_cnt_r;
   logic       ref_en, cal_start, ad_start, cal_busy, ad_busy, busy_d_r;
   logic [4:0] ad_idx, ad_best, sel_idx;
   logic [CW-1:0] cal_code;
   logic [15:0]   target;
   logic          cmd_readapt, cmd_cdr_rst, powered_r;

   function automatic logic in_table(input logic [7:0] a);
      return a >= rtac_pkg::OFS_TABLE_LO && a <= rtac_pkg::OFS_TABLE_HI;
   endfunction
   function automatic logic in_ratex(input logic [7:0] a);
      return a >= rtac_pkg::OFS_RATE_X0 && a <= rtac_pkg::OFS_RATE_X4;
   endfunction
   // boost level = sum of two-bit stage codes
   function automatic logic [5:0] boost_sum(input logic [7:0] e);
      return 6'(e[1:0]) + 6'(e[3:2]) + 6'(e[5:4]) + 6'(e[7:6]);
   endfunction

   assign cmd_readapt = wr && addr == rtac_pkg::OFS_CTRL && wdata[rtac_pkg::CTRL_READAPT];
   assign cmd_cdr_rst = wr && addr == rtac_pkg::OFS_CTRL && wdata[rtac_pkg::CTRL_CDR_RST];

   // ****************************************
   // register writes
   // ****************************************
   // host-owned driver and rate settings
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         swing_r  <= rtac_pkg::SWING_RST;
         rate_r   <= rtac_pkg::RATE_RST;
         deemph_r <= '0;
         ctrl_r   <= '0;
         mon_r    <= rtac_pkg::MON_RST;
         for (int i = 0; i < 5; i++)
            rate_x_r[i] <= '0;
      end else if (wr) begin
         unique case (addr)
            rtac_pkg::OFS_SWING:  swing_r  <= {5'h00, wdata[rtac_pkg::SWING_MSB:0]};
            rtac_pkg::OFS_RATE:   rate_r   <= {wdata[7:rtac_pkg::RATE_LSB], 4'h0};
            rtac_pkg::OFS_DEEMPH: deemph_r <= wdata;
            rtac_pkg::OFS_MON:    mon_r    <= {wdata[rtac_pkg::MON_EN_BIT], 7'h00};
            // command bits are pulses, not stored
            rtac_pkg::OFS_CTRL:   ctrl_r   <= {6'h00, wdata[1:0]} | (wdata & 8'h10);
            default: if (in_ratex(addr))
               rate_x_r[3'(addr - rtac_pkg::OFS_RATE_X0)] <= wdata;
         endcase
      end
   end

   // table entries are fully rewritable
   generate
      for (genvar g = 0; g < rtac_pkg::TABLE_N; g++) begin : g_tab
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n)
               table_r[g] <= rtac_pkg::TABLE_RST;
            else if (wr && addr == rtac_pkg::OFS_TABLE_LO + 8'(g))
               table_r[g] <= wdata;
         end
      end
   endgenerate

   // ****************************************
   // register reads
   // ****************************************
   // data valid in the cycle after the strobe only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         rdata <= '0;
      else if (!rd)
         rdata <= '0;
      else if (in_table(addr))
         rdata <= table_r[5'(addr - rtac_pkg::OFS_TABLE_LO)];
      else if (in_ratex(addr))
         rdata <= rate_x_r[3'(addr - rtac_pkg::OFS_RATE_X0)];
      else begin
         unique case (addr)
            rtac_pkg::OFS_SWING:  rdata <= swing_r;
            rtac_pkg::OFS_RATE:   rdata <= rate_r;
            rtac_pkg::OFS_DEEMPH: rdata <= deemph_r;
            rtac_pkg::OFS_MON:    rdata <= mon_r;
            rtac_pkg::OFS_CTRL:   rdata <= ctrl_r;
            rtac_pkg::OFS_STATUS: rdata <= {2'h0, data_out_en, cdr_locked, sig_det, st_r};
            rtac_pkg::OFS_COARSE: rdata <= 8'(cal_code);
            default:              rdata <= '0;  // unmapped reads zero
         endcase
      end
   end

   // ****************************************
   // reference tick and target
   // ****************************************
   // 25 MHz window clock as an enable pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_cnt_r <= '0;
         ref_en    <= 1'b0;
      end else begin
         ref_en    <= ref_cnt_r == 4'(rtac_pkg::REF_DIV - 1);
         ref_cnt_r <= (ref_cnt_r == 4'(rtac_pkg::REF_DIV - 1)) ? 4'h0 : ref_cnt_r + 4'h1;
      end
   end
   // manual ppm count and divider, or rate-derived count
   assign target = ctrl_r[rtac_pkg::CTRL_MANUAL] ? {rate_x_r[1], rate_x_r[0]} >> rate_x_r[2][2:0]
                                                 : {4'h0, rate_r[7:4], 8'h00} + 16'h0800;

   // ****************************************
   // channel state machine
   // ****************************************
   // each channel instance keeps its own sequence
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r      <= RTAC_OFF;
         retry_r   <= '0;
         cal_start <= 1'b0;
         ad_start  <= 1'b0;
         powered_r <= 1'b0;
         busy_d_r  <= 1'b0;
      end else begin
         cal_start <= 1'b0;
         ad_start  <= 1'b0;
         busy_d_r  <= cal_busy | ad_busy | cal_start | ad_start;
         if (!sig_det || ctrl_r[rtac_pkg::CTRL_SD_OVR]) begin
            st_r <= RTAC_OFF;
         end else if (cmd_cdr_rst) begin
            st_r      <= RTAC_CAL;
            cal_start <= 1'b1;
            retry_r   <= '0;
         end else begin
            unique case (st_r)
               RTAC_OFF: begin
                  // first power-up calibrates, later wakes reacquire
                  st_r      <= powered_r ? RTAC_ACQ : RTAC_CAL;
                  cal_start <= !powered_r;
                  powered_r <= 1'b1;
               end
               // start pulse counts as busy, else the state leaves before the helper starts
               RTAC_CAL: if (!cal_busy && !cal_start && !busy_d_r) begin
                  st_r     <= RTAC_ADAPT;
                  ad_start <= 1'b1;
               end
               RTAC_ACQ: begin
                  if (cdr_locked && (eye_ok || !mon_r[rtac_pkg::MON_EN_BIT])) begin
                     st_r    <= RTAC_RUN;
                     retry_r <= '0;
                  end else if (retry_r == 3'(rtac_pkg::MAX_RETRY)) begin
                     st_r      <= RTAC_CAL;
                     cal_start <= 1'b1;
                     retry_r   <= '0;
                  end else begin
                     st_r     <= RTAC_ADAPT;  // reacquire re-adapts
                     ad_start <= 1'b1;
                     retry_r  <= retry_r + 3'd1;
                  end
               end
               RTAC_ADAPT: if (!ad_busy && !ad_start && !busy_d_r)
                  st_r <= RTAC_ACQ;
               RTAC_RUN: begin
                  if (cmd_readapt) begin
                     st_r     <= RTAC_ADAPT;
                     ad_start <= 1'b1;
                  end else if (!cdr_locked)
                     st_r <= RTAC_ACQ;
               end
            endcase
         end
      end
   end

   rtac_cal #(.CW(CW)) u_cal (
      .clk      (clk),
      .rst_n    (rst_n),
      .start    (cal_start),
      .ref_en   (ref_en),
      .vco_tick (vco_tick),
      .target   (target),
      .code     (cal_code),
      .busy     (cal_busy)
   );
   rtac_adapt u_adapt (
      .clk   (clk),
      .rst_n (rst_n),
      .start (ad_start),
      .merit (merit),
      .idx   (ad_idx),
      .best  (ad_best),
      .busy  (ad_busy)
   );
   assign sel_idx = ad_busy ? ad_idx : ad_best;

   // ****************************************
   // registered outputs
   // ****************************************
   // boost frozen to best entry outside adaption
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         path_pwr           <= 1'b0;
         stage_boost        <= '0;
         boost_level        <= '0;
         stage4_limit       <= 1'b0;
         coarse_code        <= '0;
         output_swing_level <= '0;
         deemph             <= '0;
         data_out_en        <= 1'b0;
      end else begin
         path_pwr           <= st_r != RTAC_OFF;
         stage_boost        <= table_r[sel_idx];
         boost_level        <= boost_sum(table_r[sel_idx]);
         stage4_limit       <= ctrl_r[rtac_pkg::CTRL_LIMIT4];
         coarse_code        <= cal_code;
         output_swing_level <= swing_r[2:0];
         deemph             <= deemph_r;
         data_out_en        <= st_r == RTAC_RUN && cdr_locked;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   AST_PWR_OFF: assert property (@(posedge clk) disable iff (!rst_n)
      wr && addr == rtac_pkg::OFS_CTRL && wdata[0] |=> ##2 !path_pwr)
      else $error("data path not forced off");
   AST_NO_SIG: assert property (@(posedge clk) disable iff (!rst_n)
      !sig_det ##1 !sig_det |=> !path_pwr)
      else $error("data path powered without signal");
   AST_OUT_GATE: assert property (@(posedge clk) disable iff (!rst_n)
      data_out_en |-> $past(st_r) == RTAC_RUN && !ad_busy)
      else $error("output before adaption and lock");
   AST_FROZEN: assert property (@(posedge clk) disable iff (!rst_n)
      st_r == RTAC_RUN && $past(st_r) == RTAC_RUN && !$past(wr) |=> $stable(ad_best))
      else $error("boost changed while frozen");
   AST_SUM: assert property (@(posedge clk) disable iff (!rst_n)
      1 |=> boost_level == 6'(stage_boost[1:0]) + 6'(stage_boost[3:2])
                         + 6'(stage_boost[5:4]) + 6'(stage_boost[7:6]))
      else $error("boost level not stage sum");
   AST_MON_RST: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(rst_n) |-> mon_r[rtac_pkg::MON_EN_BIT])
      else $error("monitor enable not set after reset");
   AST_SWING: assert property (@(posedge clk) disable iff (!rst_n)
      wr && addr == rtac_pkg::OFS_SWING |=> ##1 output_swing_level == $past(wdata[2:0], 2))
      else $error("swing not applied");
   AST_RETRY: assert property (@(posedge clk) disable iff (!rst_n)
      st_r == RTAC_ACQ && retry_r == 3'(rtac_pkg::MAX_RETRY) && sig_det
      && !(cdr_locked && (eye_ok || !mon_r[rtac_pkg::MON_EN_BIT]))
      && !ctrl_r[0] && !cmd_cdr_rst |=> cal_start)
      else $error("calibration not started after retries");
endmodule

// *** tb/rtac_fe_model.sv ***
`timescale 1ns/1ps
// Purpose: far-end transmitter plus analog front end stand-in for one channel
// Assumes: vco rate is (code+1)/16 of clk, so each code step adds 40 ticks per window
// Notes:   merit peaks only at the boost entry the bench names as peak
module rtac_fe_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // bench stimulus
   input  wire logic       tx_on,
   input  wire logic [7:0] peak,
   // controls from the channel
   input  wire logic       path_pwr,
   input  wire logic [7:0] stage_boost,
   input  wire logic [3:0] coarse_code,
   // front end status
   output logic            sig_det,
   output logic            vco_tick,
   output logic            cdr_locked,
   output logic [7:0]      merit
);
   logic [3:0] acc_r;
   logic [6:0] lock_cnt_r;

   // energy only while the far end sends; flat merit elsewhere gives one winner
   assign sig_det    = tx_on;
   assign merit      = (stage_boost == peak) ? 8'hc8 : 8'h10;
   assign cdr_locked = (lock_cnt_r == 7'h64);

   // vco divider clears to zero when the data path is down, no free-running ticks
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         acc_r    <= 4'h0;
         vco_tick <= 1'b0;
      end else begin
         {vco_tick, acc_r} <= path_pwr ? ({1'b0, acc_r} + 5'(coarse_code) + 5'h01) : 5'h00;
      end
   end

   // lock needs 100 powered cycles of signal; drops at once on loss
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_cnt_r <= 7'h00;
      end else if (path_pwr && tx_on) begin
         lock_cnt_r <= cdr_locked ? lock_cnt_r : lock_cnt_r + 7'h01;
      end else begin
         lock_cnt_r <= 7'h00;
      end
   end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
// Purpose: self-checking bench for one retimer channel control block
// Assumes: read data stand the cycle after the read strobe
// Notes:   coarse expectations follow the model: count = 40 * (code + 1)
module tb;
   // ****************************************
   // signals
   // ****************************************
   logic       clk;
   logic       rst_n;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       sig_det;
   logic       vco_tick;
   logic       cdr_locked;
   logic       eye_ok;
   logic [7:0] merit;
   logic       path_pwr;
   logic [7:0] stage_boost;
   logic [5:0] boost_level;
   logic       stage4_limit;
   logic [3:0] coarse_code;
   logic [2:0] output_swing_level;
   logic [7:0] deemph;
   logic       data_out_en;
   logic       tx_on;
   logic [7:0] peak;
   int         err_total;
   int         n_compared;

   rtac_channel #(.CW(4)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .sig_det(sig_det), .vco_tick(vco_tick), .cdr_locked(cdr_locked), .eye_ok(eye_ok),
      .merit(merit), .path_pwr(path_pwr), .stage_boost(stage_boost), .boost_level(boost_level),
      .stage4_limit(stage4_limit), .coarse_code(coarse_code), .output_swing_level(output_swing_level),
      .deemph(deemph), .data_out_en(data_out_en));
   rtac_fe_model u_fe (.clk(clk), .rst_n(rst_n), .tx_on(tx_on), .peak(peak), .path_pwr(path_pwr),
      .stage_boost(stage_boost), .coarse_code(coarse_code), .sig_det(sig_det), .vco_tick(vco_tick),
      .cdr_locked(cdr_locked), .merit(merit));

   // 250 MHz clock
   always #2 clk = ~clk;

   // ****************************************
   // tasks
   // ****************************************
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one gap cycle after each strobe so no edge assigns a strobe twice
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, exp);
   endtask

   // sel 0 output enable, 1 path power, 2 second table winner on the boost port
   task automatic wait_for(input int sel, input logic v, input int lim);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge clk);
         #1;
         hit = (((sel == 0) ? data_out_en : (sel == 1) ? path_pwr : (stage_boost == 8'hff)) === v);
      end
      if (!hit) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, ~v, v);
         summarize();
      end
   endtask

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      eye_ok = 1'b0;
      tx_on = 1'b0;
      peak = 8'he4;
      err_total = 0;
      n_compared = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk(8'(path_pwr), 8'h00);
      chk(8'(output_swing_level), 8'h04);
      chk(stage_boost, 8'h55);
      chk(8'(boost_level), 8'h04);
      // reset values and an unmapped place; monitor stays enabled all run
      reg_rd(rtac_pkg::OFS_MON, 8'h80);
      reg_rd(rtac_pkg::OFS_TABLE_HI, 8'h55);
      reg_wr(8'hf0, 8'h3c);
      reg_rd(8'hf0, 8'h00);
      // host sets the driver and rate fields
      reg_wr(rtac_pkg::OFS_SWING, 8'h07);
      reg_wr(rtac_pkg::OFS_DEEMPH, 8'h3c);
      reg_wr(rtac_pkg::OFS_RATE, 8'ha0);
      reg_wr(rtac_pkg::OFS_RATE_X4, 8'h5a);
      reg_wr(8'h4b, 8'he4);
      reg_wr(8'h50, 8'hff);
      // manual target 0x0140 = 320 counts, code 7 in the model
      reg_wr(8'h60, 8'h40);
      reg_wr(8'h61, 8'h01);
      reg_wr(8'h62, 8'h00);
      reg_wr(rtac_pkg::OFS_CTRL, 8'h12);
      reg_rd(rtac_pkg::OFS_RATE, 8'ha0);
      reg_rd(rtac_pkg::OFS_RATE_X4, 8'h5a);
      reg_rd(8'h4b, 8'he4);
      #1;
      chk(8'(output_swing_level), 8'h07);
      chk(deemph, 8'h3c);
      chk(8'(stage4_limit), 8'h01);
      // signal arrives, eye check failing holds the output off
      tx_on <= 1'b1;
      wait_for(1, 1'b1, 50);
      // long enough for four failed attempts and the start of a fresh calibration
      repeat (14000) @(posedge clk);
      #1;
      chk(8'(data_out_en), 8'h00);
      eye_ok <= 1'b1;
      wait_for(0, 1'b1, 20000);
      chk(8'(coarse_code), 8'h07);
      chk(stage_boost, 8'he4);
      chk(8'(boost_level), 8'h06);
      reg_rd(rtac_pkg::OFS_COARSE, 8'h07);
      reg_rd(rtac_pkg::OFS_STATUS, 8'h3c);
      // best entry moves, boost must hold until re-adapt
      peak <= 8'hff;
      repeat (1000) @(posedge clk);
      #1;
      chk(stage_boost, 8'he4);
      reg_wr(rtac_pkg::OFS_CTRL, 8'h16);
      wait_for(2, 1'b1, 2000);
      chk(8'(boost_level), 8'h0c);
      wait_for(0, 1'b1, 2000);
      chk(stage_boost, 8'hff);
      // recovery reset with target 0x00f0 >> 1 = 120, code 2; host way to re-adapt
      reg_wr(8'h60, 8'hf0);
      reg_wr(8'h61, 8'h00);
      reg_wr(8'h62, 8'h01);
      reg_wr(rtac_pkg::OFS_CTRL, 8'h1a);
      wait_for(0, 1'b0, 200);
      wait_for(0, 1'b1, 20000);
      chk(8'(coarse_code), 8'h02);
      chk(stage_boost, 8'hff);
      // forced off, then released
      reg_wr(rtac_pkg::OFS_CTRL, 8'h13);
      wait_for(1, 1'b0, 50);
      chk(8'(data_out_en), 8'h00);
      reg_wr(rtac_pkg::OFS_CTRL, 8'h12);
      wait_for(1, 1'b1, 50);
      // loss of signal powers the path down
      tx_on <= 1'b0;
      wait_for(1, 1'b0, 50);
      chk(8'(data_out_en), 8'h00);
      summarize();
   end
endmodule
